// ### logic/srgm_top.sv
// module: supply reset and gain manager for a hearing-aid audio path
`timescale 1ns/10ps
`default_nettype none
module srgm_top #(
  parameter int unsigned TICK_DIV   = srgm_pkg::TICK_CYCLES,
  parameter int unsigned INST_MS    = srgm_pkg::INST_PERIOD_MS,
  parameter int unsigned AVG_MS     = srgm_pkg::AVG_STEP_MS,
  parameter int unsigned LOWBAT_MS  = srgm_pkg::LOWBAT_REP_MS
) (
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic [1:0]  POLICY_I,
  input  wire logic [13:0] POR_DELAY_MS_I,
  input  wire logic        LOWBAT_EN_I,
  input  wire logic        BUTTON_I,
  input  wire logic        INST_BELOW_095_I,
  input  wire logic        INST_ABOVE_100_I,
  input  wire logic        INST_ABOVE_110_I,
  input  wire logic        AVG_BELOW_095_I,
  input  wire logic        AVG_ABOVE_110_I,
  input  wire logic        BELOW_RAMPDOWN_I,
  input  wire logic        BELOW_060_I,
  input  wire logic        BELOW_LOWBAT_I,
  output logic             AUDIO_EN_O,
  output logic             MUTE_O,
  output logic [5:0]       GAIN_CUT_DB_O,
  output logic             BUTTON_O,
  output logic             RESTORE_MEM_O,
  output logic             LOAD_MEM_A_O,
  output logic             LOWBAT_REQ_O,
  output logic             HW_RESET_O
);
  srgm_tick_if tick_bus ();
  srgm_tick_div #(.DIV(TICK_DIV)) u_div (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RST_N_I),
    .tick_o  (tick_bus.src)
  );
  wire logic tick = tick_bus.tick;

  srgm_pkg::srgm_st_t  st;
  srgm_pkg::srgm_pol_t pol;
  logic [13:0] por_cnt;
  logic [13:0] por_lim;
  logic        deep_seen_060;
  logic        mute_shallow;
  logic        mute_deep;
  logic        mute_avg;
  logic [1:0]  inst_steps;
  logic [4:0]  avg_steps;
  logic [16:0] inst_timer;
  logic        inst_hold;
  logic        period_ok_110;
  logic        period_ok_100;
  logic [16:0] avg_timer;
  logic [18:0] lb_timer;
  logic        lb_active;

  // reserved code falls back to shallow so exactly one policy governs
  always_comb begin
    pol = srgm_pkg::srgm_pol_t'(POLICY_I);
    if (pol == srgm_pkg::SRGM_POL_RSVD) begin
      pol = srgm_pkg::SRGM_POL_SHALLOW;
    end
  end

  // clamp to eleven seconds
  always_comb begin
    por_lim = POR_DELAY_MS_I;
    if (POR_DELAY_MS_I > 14'(srgm_pkg::POR_MAX_MS)) begin
      por_lim = 14'(srgm_pkg::POR_MAX_MS);
    end
  end

  wire logic shutdown_shallow = (pol == srgm_pkg::SRGM_POL_SHALLOW) && BELOW_RAMPDOWN_I;
  wire logic shutdown_deep    = (pol == srgm_pkg::SRGM_POL_DEEP) && BELOW_060_I;
  wire logic shutdown_adv     = (pol == srgm_pkg::SRGM_POL_ADV) && BELOW_RAMPDOWN_I;
  wire logic shutdown         = shutdown_shallow || shutdown_deep || shutdown_adv;
  wire logic running          = (st == srgm_pkg::SRGM_ST_RUN);
  wire logic adv_run          = running && (pol == srgm_pkg::SRGM_POL_ADV);

  // top-level sequencer: off, power-on delay, run
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      st            <= srgm_pkg::SRGM_ST_POR;
      por_cnt       <= srgm_pkg::POR_DLY_RST;
      deep_seen_060 <= 1'b1;
      RESTORE_MEM_O <= 1'b0;
      LOAD_MEM_A_O  <= 1'b0;
      HW_RESET_O    <= 1'b0;
    end else begin
      RESTORE_MEM_O <= 1'b0;
      LOAD_MEM_A_O  <= 1'b0;
      HW_RESET_O    <= 1'b0;
      unique case (st)
        srgm_pkg::SRGM_ST_OFF: begin
          if (BELOW_060_I) begin
            deep_seen_060 <= 1'b1;
          end
          // stays off until 1.1 V
          if (INST_ABOVE_110_I && !BELOW_RAMPDOWN_I) begin
            st      <= srgm_pkg::SRGM_ST_POR;
            por_cnt <= 14'h0000;
          end
        end
        srgm_pkg::SRGM_ST_POR: begin
          if (shutdown) begin
            st         <= srgm_pkg::SRGM_ST_OFF;
            HW_RESET_O <= 1'b1;
          end else if (tick) begin
            // a setting of d runs d ticks, in line with zero meaning no delay
            if (por_cnt + 14'h0001 >= por_lim) begin
              st <= srgm_pkg::SRGM_ST_RUN;
              if (deep_seen_060) begin
                LOAD_MEM_A_O <= 1'b1;
              end else begin
                RESTORE_MEM_O <= 1'b1;
              end
              deep_seen_060 <= 1'b0;
            end else begin
              por_cnt <= por_cnt + 14'h0001;
            end
          end else if (por_lim == 14'h0000) begin
            st <= srgm_pkg::SRGM_ST_RUN;
            LOAD_MEM_A_O  <= deep_seen_060;
            RESTORE_MEM_O <= !deep_seen_060;
            deep_seen_060 <= 1'b0;
          end
        end
        srgm_pkg::SRGM_ST_RUN: begin
          if (shutdown) begin
            st            <= srgm_pkg::SRGM_ST_OFF;
            HW_RESET_O    <= 1'b1;
            // deep policy always reloads the first memory
            deep_seen_060 <= shutdown_deep || BELOW_060_I;
          end
        end
        default: begin
          st <= srgm_pkg::SRGM_ST_OFF;
        end
      endcase
    end
  end

  // button only passes after the delay
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      BUTTON_O   <= 1'b0;
      AUDIO_EN_O <= 1'b0;
    end else begin
      BUTTON_O   <= BUTTON_I && running;
      AUDIO_EN_O <= running;
    end
  end

  // shallow mute with hysteresis 0.95 V to 1.1 V
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      mute_shallow <= 1'b0;
    end else if (!running || pol != srgm_pkg::SRGM_POL_SHALLOW) begin
      mute_shallow <= 1'b0;
    end else if (INST_BELOW_095_I) begin
      mute_shallow <= 1'b1;
    end else if (INST_ABOVE_110_I) begin
      mute_shallow <= 1'b0;
    end
  end

  // deep mute latches until the 0.6 V reset
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      mute_deep <= 1'b0;
    end else if (!running || pol != srgm_pkg::SRGM_POL_DEEP) begin
      mute_deep <= 1'b0;
    end else if (INST_BELOW_095_I) begin
      mute_deep <= 1'b1;
    end
  end

  // instantaneous cuts: 30 s periods, hold-off after each cut
  wire logic inst_period_end = tick && (inst_timer >= 17'(INST_MS - 1));
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      inst_steps    <= 2'h0;
      inst_timer    <= 17'h00000;
      inst_hold     <= 1'b0;
      period_ok_110 <= 1'b1;
      period_ok_100 <= 1'b1;
    end else if (!adv_run) begin
      inst_steps    <= 2'h0;
      inst_timer    <= 17'h00000;
      inst_hold     <= 1'b0;
      period_ok_110 <= 1'b1;
      period_ok_100 <= 1'b1;
    end else begin
      if (tick) begin
        inst_timer <= inst_period_end ? 17'h00000 : inst_timer + 17'h00001;
      end
      if (inst_period_end) begin
        inst_hold     <= 1'b0;
        period_ok_110 <= 1'b1;
        period_ok_100 <= 1'b1;
        if (inst_hold) begin
          inst_steps <= inst_steps;
        end else if (period_ok_110 && INST_ABOVE_110_I) begin
          inst_steps <= 2'h0;
        end else if (period_ok_100 && INST_ABOVE_100_I && inst_steps == 2'h2) begin
          inst_steps <= 2'h1;
        end
      end else begin
        if (!INST_ABOVE_110_I) begin
          period_ok_110 <= 1'b0;
        end
        if (!INST_ABOVE_100_I) begin
          period_ok_100 <= 1'b0;
        end
        if (!inst_hold && INST_BELOW_095_I && !AVG_BELOW_095_I
            && inst_steps < 2'(srgm_pkg::INST_MAX_STEPS)) begin
          inst_steps <= inst_steps + 2'h1;
          inst_hold  <= 1'b1;
          inst_timer <= 17'h00000;
        end
      end
    end
  end

  // average cuts: 1 dB per 10 s step
  wire logic avg_step = tick && (avg_timer >= 17'(AVG_MS - 1));
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      avg_steps <= 5'h00;
      avg_timer <= 17'h00000;
      mute_avg  <= 1'b0;
    end else if (!adv_run) begin
      avg_steps <= 5'h00;
      avg_timer <= 17'h00000;
      mute_avg  <= 1'b0;
    end else if (AVG_BELOW_095_I) begin
      if (tick) begin
        avg_timer <= avg_step ? 17'h00000 : avg_timer + 17'h00001;
      end
      if (avg_step) begin
        if (avg_steps < 5'(srgm_pkg::AVG_MAX_STEPS)) begin
          avg_steps <= avg_steps + 5'h01;
        end
        if (avg_steps >= 5'(srgm_pkg::AVG_MAX_STEPS - 1)) begin
          mute_avg <= 1'b1;
        end
      end
    end else if (AVG_ABOVE_110_I) begin
      mute_avg <= 1'b0;
      if (mute_avg) begin
        // unmute first, then a full step before the first raise
        avg_timer <= 17'h00000;
      end else if (tick) begin
        avg_timer <= avg_step ? 17'h00000 : avg_timer + 17'h00001;
      end
      if (avg_step && !mute_avg && avg_steps != 5'h00) begin
        avg_steps <= avg_steps - 5'h01;
      end
    end else begin
      avg_timer <= 17'h00000;
    end
  end

  // outputs registered, recomputed every cycle from the run state, mute flags and step counters
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      MUTE_O        <= 1'b1;
      GAIN_CUT_DB_O <= 6'h00;
    end else begin
      MUTE_O        <= !running || mute_shallow || mute_deep || mute_avg;
      GAIN_CUT_DB_O <= 6'(inst_steps * srgm_pkg::INST_STEP_DB) + 6'(avg_steps);
    end
  end

  // low-battery request, repeated every five minutes
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      lb_active    <= 1'b0;
      lb_timer     <= 19'h00000;
      LOWBAT_REQ_O <= 1'b0;
    end else begin
      LOWBAT_REQ_O <= 1'b0;
      if (!running || !LOWBAT_EN_I) begin
        lb_active <= 1'b0;
        lb_timer  <= 19'h00000;
      end else if (!lb_active) begin
        if (BELOW_LOWBAT_I) begin
          lb_active    <= 1'b1;
          LOWBAT_REQ_O <= 1'b1;
          lb_timer     <= 19'h00000;
        end
      end else if (tick) begin
        if (lb_timer >= 19'(LOWBAT_MS - 1)) begin
          lb_timer     <= 19'h00000;
          LOWBAT_REQ_O <= 1'b1;
        end else begin
          lb_timer <= lb_timer + 19'h00001;
        end
      end
    end
  end

  a_button_blocked: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    !running |=> !BUTTON_O) else $error("button passed during delay");
  a_audio_follows: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    $rose(running) |=> AUDIO_EN_O) else $error("audio not enabled after delay");
  a_shallow_mute: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    running && pol == srgm_pkg::SRGM_POL_SHALLOW && INST_BELOW_095_I && !shutdown
    |=> ##1 MUTE_O) else $error("shallow policy failed to mute");
  a_inst_max: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    inst_steps <= 2'h2) else $error("too many instantaneous cuts");
  a_avg_max: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    avg_steps <= 5'h12) else $error("too many average cuts");
  a_hold_blocks: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    adv_run && inst_hold && !inst_period_end |=> inst_steps == $past(inst_steps))
    else $error("cut applied during hold-off");
  a_band_stable: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    adv_run && !AVG_BELOW_095_I && !AVG_ABOVE_110_I |=> $stable(avg_steps))
    else $error("average cut moved in band");
  sequence s_gone_off;
    st == srgm_pkg::SRGM_ST_OFF ##1 !AUDIO_EN_O;
  endsequence
  a_shutdown_off: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    running && shutdown |=> s_gone_off)
    else $error("no reset on shutdown");
endmodule
`default_nettype wire

// ### common/srgm_pkg.sv
// package: constants and types for the supply reset gain manager
package srgm_pkg;
  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned TICK_MS       = 1;
  // one-millisecond tick from the control clock
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned INST_PERIOD_S = 30;
  localparam int unsigned AVG_STEP_S    = 10;
  localparam int unsigned LOWBAT_REP_S  = 300;
  localparam int unsigned POR_MAX_S     = 11;
  localparam int unsigned INST_PERIOD_MS = INST_PERIOD_S * 1000;
  localparam int unsigned AVG_STEP_MS    = AVG_STEP_S * 1000;
  localparam int unsigned LOWBAT_REP_MS  = LOWBAT_REP_S * 1000;
  localparam int unsigned POR_MAX_MS     = POR_MAX_S * 1000;
  localparam int unsigned INST_STEP_DB  = 3;
  localparam int unsigned INST_MAX_STEPS = 2;
  localparam int unsigned AVG_MAX_STEPS = 18;
  localparam logic [13:0] POR_DLY_RST   = 14'h0000;
  typedef enum logic [1:0] {
    SRGM_POL_SHALLOW,
    SRGM_POL_DEEP,
    SRGM_POL_ADV,
    SRGM_POL_RSVD
  } srgm_pol_t;
  typedef enum logic [1:0] {
    SRGM_ST_OFF,
    SRGM_ST_POR,
    SRGM_ST_RUN
  } srgm_st_t;
endpackage

// ### common/srgm_tick_if.sv
// interface: millisecond tick between the divider and the manager
`timescale 1ns/10ps
`default_nettype none
interface srgm_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface
`default_nettype wire

// ### logic/srgm_tick_div.sv
// module: divider producing a one-cycle millisecond enable
`timescale 1ns/10ps
`default_nettype none
module srgm_tick_div #(
  parameter int unsigned DIV = srgm_pkg::TICK_CYCLES
) (
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  srgm_tick_if.src    tick_o
);
  logic [31:0] cnt;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt         <= 32'h0;
      tick_o.tick <= 1'b0;
    end else if (cnt >= DIV - 1) begin
      cnt         <= 32'h0;
      tick_o.tick <= 1'b1;
    end else begin
      cnt         <= cnt + 32'h1;
      tick_o.tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### tb/srgm_supply_model.sv
// supply comparator model: turns supply levels in mV into flags
`timescale 1ns/10ps
`default_nettype none
module srgm_supply_model #(
  parameter int RAMP_MV   = 800,
  parameter int LOWBAT_MV = 1050
) (
  input  wire logic        clk_i,
  input  wire logic [11:0] inst_mv_i,
  input  wire logic [11:0] avg_mv_i,
  output logic             inst_below_095_o,
  output logic             inst_above_100_o,
  output logic             inst_above_110_o,
  output logic             avg_below_095_o,
  output logic             avg_above_110_o,
  output logic             below_rampdown_o,
  output logic             below_060_o,
  output logic             below_lowbat_o
);
  // registered like a real synchroniser, so flags never change mid-cycle
  always_ff @(posedge clk_i) begin
    inst_below_095_o <= inst_mv_i < 12'h3b6;
    inst_above_100_o <= inst_mv_i > 12'h3e8;
    inst_above_110_o <= inst_mv_i > 12'h44c;
    avg_below_095_o  <= avg_mv_i < 12'h3b6;
    avg_above_110_o  <= avg_mv_i > 12'h44c;
    below_rampdown_o <= int'(inst_mv_i) < RAMP_MV;
    below_060_o      <= inst_mv_i < 12'h258;
    below_lowbat_o   <= int'(inst_mv_i) < LOWBAT_MV;
  end
endmodule
`default_nettype wire

// ### tb/supply_reset_gain_manager_bench.sv
// self-checking bench for the supply reset gain manager
`timescale 1ns/10ps
`default_nettype none
module supply_reset_gain_manager_bench;
  localparam int TK = 4;
  localparam int LB = 40;
  logic clk = 1'b0, rst_n = 1'b0, lb_en = 1'b0, btn = 1'b0;
  logic [1:0] pol = 2'h0;
  logic [13:0] por = 14'h0000;
  logic [11:0] inst = 12'h47e, avg = 12'h47e;
  logic ib95, ia100, ia110, ab95, aa110, brd, b60, blb;
  logic aen, mute, btn_o, rest, mema, beep, hwr;
  logic [5:0] gain;
  logic s_rst = 1'b0, s_rest = 1'b0, s_mema = 1'b0;
  int n_beep = 0, errors = 0, n_tests = 0, k, d;
  int seed = 32'hd9d125af;
  always #2 clk = ~clk;
  srgm_supply_model i_srgm_supply_model (.clk_i(clk), .inst_mv_i(inst), .avg_mv_i(avg),
    .inst_below_095_o(ib95), .inst_above_100_o(ia100), .inst_above_110_o(ia110),
    .avg_below_095_o(ab95), .avg_above_110_o(aa110), .below_rampdown_o(brd),
    .below_060_o(b60), .below_lowbat_o(blb));
  srgm_top #(.TICK_DIV(TK), .INST_MS(20), .AVG_MS(10), .LOWBAT_MS(LB)) i_srgm_top (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .POLICY_I(pol), .POR_DELAY_MS_I(por),
    .LOWBAT_EN_I(lb_en), .BUTTON_I(btn), .INST_BELOW_095_I(ib95),
    .INST_ABOVE_100_I(ia100), .INST_ABOVE_110_I(ia110), .AVG_BELOW_095_I(ab95),
    .AVG_ABOVE_110_I(aa110), .BELOW_RAMPDOWN_I(brd), .BELOW_060_I(b60),
    .BELOW_LOWBAT_I(blb), .AUDIO_EN_O(aen), .MUTE_O(mute), .GAIN_CUT_DB_O(gain),
    .BUTTON_O(btn_o), .RESTORE_MEM_O(rest), .LOAD_MEM_A_O(mema),
    .LOWBAT_REQ_O(beep), .HW_RESET_O(hwr));
  // pulses last one cycle, so catch them in sticky flags and count the beeps
  always @(posedge clk) begin
    if (hwr === 1'b1) s_rst <= 1'b1;
    if (rest === 1'b1) s_rest <= 1'b1;
    if (mema === 1'b1) s_mema <= 1'b1;
    if (beep === 1'b1) n_beep <= n_beep + 1;
  end
  function automatic logic [5:0] probe(input int sel);
    case (sel)
      0: probe = {5'h00, aen};
      1: probe = {5'h00, mute};
      2: probe = gain;
      3: probe = {5'h00, s_rst};
      4: probe = {5'h00, s_rest};
      5: probe = {5'h00, s_mema};
      default: probe = {5'h00, btn_o};
    endcase
  endfunction
  function automatic int beeps(input int cyc);
    beeps = cyc / (LB * TK) + 1;
  endfunction
  function automatic logic [11:0] dip();
    dip = 12'h320 + 12'(($random(seed)) & 32'h7f);
  endfunction
  task automatic check(input string what, input logic [5:0] exp, input logic [5:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wait_for(input string what, input int sel, input logic [5:0] exp,
                          input int max);
    for (int i = 0; i < max && probe(sel) !== exp; i++) @(negedge clk);
    check(what, exp, probe(sel));
  endtask
  task automatic stay(input string what, input int sel, input logic [5:0] exp, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      if (probe(sel) !== exp) break;
    end
    check(what, exp, probe(sel));
  endtask
  task automatic supply(input logic [11:0] i, input logic [11:0] a);
    @(posedge clk);
    inst <= i;
    avg <= a;
  endtask
  task automatic clr();
    @(negedge clk);
    s_rst = 1'b0;
    s_rest = 1'b0;
    s_mema = 1'b0;
  endtask
  task automatic done(input string name);
    $display("test %s done", name);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #(4 * 20000);
    errors++;
    conclude();
  end
  initial begin
    d = 2 + (($random(seed)) & 7);
    @(posedge clk);
    por <= 14'(d);
    btn <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("reset audio", 6'h00, probe(0));
    check("reset mute", 6'h01, probe(1));
    @(posedge clk);
    rst_n <= 1'b1;
    for (k = 0; k < 200 && aen !== 1'b1; k++) begin
      @(negedge clk);
      if (btn_o !== 1'b0 && aen !== 1'b1) check("button in delay", 6'h00, probe(6));
    end
    check("por delay", 6'h01, 6'((k >= (d - 1) * TK) && (k <= d * TK + 4)));
    check("por memory a", 6'h01, probe(5));
    wait_for("button run", 6, 6'h01, 4);
    btn <= 1'b0;
    done("power on");
    supply(dip(), 12'h47e);
    wait_for("shallow mute", 1, 6'h01, 5);
    supply(12'h41a, 12'h47e);
    stay("shallow hold", 1, 6'h01, 50);
    supply(12'h47e, 12'h47e);
    wait_for("shallow unmute", 1, 6'h00, 5);
    supply(12'h3f0, 12'h47e);
    n_beep = 0;
    repeat (200) @(posedge clk);
    check("beep off", 6'h00, 6'(n_beep));
    lb_en <= 1'b1;
    n_beep = 0;
    repeat (340) @(posedge clk);
    check("beep count", 6'(beeps(340)), 6'(n_beep));
    lb_en <= 1'b0;
    done("shallow");
    for (int m = 0; m < 4; m++) begin
      clr();
      pol <= (m == 3) ? 2'h2 : (m == 2) ? 2'h3 : 2'h0;
      supply((m == 1) ? 12'h1f4 : 12'h2ee, 12'h47e);
      wait_for("shutdown", 3, 6'h01, 6);
      wait_for("off", 0, 6'h00, 6);
      supply(12'h47e, 12'h47e);
      wait_for("restart", 0, 6'h01, d * TK + 20);
      check("restore memory", {5'h00, m != 1}, probe(4));
      check("memory a", {5'h00, m == 1}, probe(5));
    end
    done("restarts");
    clr();
    pol <= 2'h1;
    supply(dip(), 12'h47e);
    wait_for("deep mute", 1, 6'h01, 5);
    supply(12'h2ee, 12'h47e);
    stay("deep no reset", 0, 6'h01, 30);
    check("deep still mute", 6'h01, probe(1));
    supply(12'h1f4, 12'h47e);
    wait_for("deep reset", 3, 6'h01, 6);
    supply(12'h47e, 12'h47e);
    wait_for("deep restart", 0, 6'h01, d * TK + 20);
    check("deep memory a", 6'h01, probe(5));
    done("deep");
    pol <= 2'h2;
    supply(dip(), 12'h3e8);
    wait_for("first cut", 2, 6'h03, 4);
    stay("hold off", 2, 6'h03, 60);
    wait_for("second cut", 2, 6'h06, 200);
    stay("two cuts max", 2, 6'h06, 250);
    supply(12'h41a, 12'h3e8);
    wait_for("back to one", 2, 6'h03, 400);
    supply(12'h47e, 12'h3e8);
    wait_for("cuts gone", 2, 6'h00, 400);
    done("instant");
    supply(12'h47e, 12'h384);
    wait_for("avg step", 2, 6'h01, 60);
    for (k = 0; k < 60 && gain !== 6'h02; k++) @(negedge clk);
    check("avg spacing", 6'h01, 6'((k >= 10 * TK - 2) && (k <= 10 * TK + 2)));
    wait_for("avg mute", 1, 6'h01, 700);
    check("avg max", 6'h12, probe(2));
    supply(12'h47e, 12'h47e);
    wait_for("avg unmute", 1, 6'h00, 5);
    wait_for("avg raise", 2, 6'h11, 60);
    supply(12'h47e, 12'h3e8);
    stay("avg band", 2, 6'h11, 100);
    supply(dip(), 12'h3e8);
    wait_for("separate counts", 2, 6'h14, 5);
    supply(12'h47e, 12'h47e);
    wait_for("all restored", 2, 6'h00, 1500);
    done("average");
    conclude();
  end
endmodule
`default_nettype wire
